//--- logic/icsq_pkg.sv
`default_nettype none
package icsq_pkg;

    localparam int CLK_PERIOD_PS     = 8000;
    localparam int CAL_RUN_TIME_PS   = 1000000;
    localparam int CAL_APPLY_TIME_PS = 30000;
    localparam int CAL_APPLY_NCK     = 8;
    localparam int CAL_DFLT_TIME_PS  = 50000;
    localparam int CAL_DFLT_NCK      = 3;

    // least times round up to whole clocks
    localparam int CAL_RUN_CYC =
        (CAL_RUN_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CAL_APPLY_NS_CYC =
        (CAL_APPLY_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CAL_APPLY_CYC = (CAL_APPLY_NS_CYC > CAL_APPLY_NCK) ?
        CAL_APPLY_NS_CYC : CAL_APPLY_NCK;
    localparam int CAL_DFLT_NS_CYC =
        (CAL_DFLT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CAL_DFLT_CYC = (CAL_DFLT_NS_CYC > CAL_DFLT_NCK) ?
        CAL_DFLT_NS_CYC : CAL_DFLT_NCK;

    localparam int CODE_W = 8;
    localparam logic [7:0] DEFAULT_CODE = 8'h80;

    // cal_reset_mode_reg address on the mode register write path
    localparam logic [5:0] CAL_RESET_MODE_REG = 6'h0a;
    localparam int         CAL_RESET_BIT      = 0;

    // software register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RESULT = 8'h08;
    localparam logic [7:0] REG_CODE0  = 8'h0c;
    localparam logic [7:0] REG_CODE1  = 8'h10;
    localparam logic [7:0] REG_IGNORE = 8'h14;

    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    typedef enum logic [1:0] {
        ICSQ_IDLE,
        ICSQ_APPLY_WAIT,
        ICSQ_DFLT_WAIT
    } icsq_chan_state_t;

endpackage : icsq_pkg
`default_nettype wire

//--- logic/icsq_chan.sv
`timescale 1ns/100ps
`default_nettype none
module icsq_chan #(
    parameter int CODE_W = 8
) (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              apply,
    input  wire logic              dflt,
    input  wire logic [CODE_W-1:0] result,
    output logic      [CODE_W-1:0] code,
    output logic                   busy,
    output logic                   is_default
);

    typedef struct packed {
        icsq_pkg::icsq_chan_state_t st;
        logic [3:0]                 cnt;
        logic [CODE_W-1:0]          pend;
        logic [CODE_W-1:0]          code;
        logic                       is_default;
    } icsq_chan_t;

    localparam logic [3:0] APPLY_LAST = 4'(icsq_pkg::CAL_APPLY_CYC - 1);
    localparam logic [3:0] DFLT_LAST  = 4'(icsq_pkg::CAL_DFLT_CYC - 1);

    icsq_chan_t s;
    icsq_chan_t next_s;

    always_comb begin
        next_s = s;
        case (s.st)
            icsq_pkg::ICSQ_IDLE: begin
                if (dflt) begin
                    next_s.st  = icsq_pkg::ICSQ_DFLT_WAIT;
                    next_s.cnt = 4'h0;
                end else if (apply) begin
                    // result sampled now; drivers keep old code meanwhile
                    next_s.pend = result;
                    next_s.st   = icsq_pkg::ICSQ_APPLY_WAIT;
                    next_s.cnt  = 4'h0;
                end
            end
            icsq_pkg::ICSQ_APPLY_WAIT: begin
                next_s.cnt = s.cnt + 4'h1;
                if (s.cnt == APPLY_LAST) begin
                    next_s.code       = s.pend;
                    next_s.is_default = 1'b0;
                    next_s.st         = icsq_pkg::ICSQ_IDLE;
                end
            end
            icsq_pkg::ICSQ_DFLT_WAIT: begin
                next_s.cnt = s.cnt + 4'h1;
                if (s.cnt == DFLT_LAST) begin
                    next_s.code       = CODE_W'(icsq_pkg::DEFAULT_CODE);
                    next_s.is_default = 1'b1;
                    next_s.st         = icsq_pkg::ICSQ_IDLE;
                end
            end
            default: begin
                next_s.st = icsq_pkg::ICSQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s.st         <= icsq_pkg::ICSQ_IDLE;
            s.cnt        <= 4'h0;
            s.pend       <= CODE_W'(icsq_pkg::DEFAULT_CODE);
            s.code       <= CODE_W'(icsq_pkg::DEFAULT_CODE);
            s.is_default <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign code       = s.code;
    assign busy       = (s.st != icsq_pkg::ICSQ_IDLE);
    assign is_default = s.is_default;

endmodule : icsq_chan
`default_nettype wire

//--- logic/icsq_top.sv
// Functional notes
// - calibration runs by a begin command and is applied by an apply.
// - drivers keep the old code until apply and its wait are done.
// - writing one to reset register bit zero restores default code.
// - a begin during a running calibration is ignored.
// - each channel has its own apply; both may come together.
// - apply loads the most recently finished calibration result.
// - default write resets only the issuing channel's code.
// - begin may come on either or both channels at any time outside power-down.
`timescale 1ns/100ps
`default_nettype none
module icsq_top #(
    parameter int CODE_W = 8
) (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic [1:0]        multipurpose_command_begin,
    input  wire logic [1:0]        multipurpose_command_apply,
    input  wire logic [1:0]        mode_reg_write,
    input  wire logic [11:0]       mode_reg_addr,
    input  wire logic [15:0]       mode_reg_data,
    input  wire logic [1:0]        power_down,
    input  wire logic [CODE_W-1:0] cal_resistor_pin_code,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic      [31:0]       reg_rdata,
    output logic      [CODE_W-1:0] drive_code0,
    output logic      [CODE_W-1:0] drive_code1,
    output logic                   cal_in_progress
);

    typedef struct packed {
        logic [CODE_W-1:0] meas_s1;
        logic [CODE_W-1:0] meas_s2;
        logic [CODE_W-1:0] meas_s3;
        logic [CODE_W-1:0] meas_hold;
        logic              running;
        logic [7:0]        run_cnt;
        logic [CODE_W-1:0] result;
        logic              result_valid;
        logic              ctrl_enable;
        logic [15:0]       ignore_cnt;
        logic [31:0]       rdata;
        logic [CODE_W-1:0] out_code0;
        logic [CODE_W-1:0] out_code1;
        logic              out_running;
    } icsq_top_t;

    localparam logic [7:0] RUN_LAST = 8'(icsq_pkg::CAL_RUN_CYC - 1);

    icsq_top_t s;
    icsq_top_t next_s;

    logic [1:0]        apply_ok;
    logic [1:0]        dflt_req;
    logic [CODE_W-1:0] chan_code [2];
    logic [1:0]        chan_busy;
    logic [1:0]        chan_dflt;

    // begin and apply are gated by power-down; a begin in power-down
    // is illegal for the controller and is simply dropped here
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            apply_ok[i] = multipurpose_command_apply[i]
                          && !power_down[i];
            dflt_req[i] = mode_reg_write[i]
                && (mode_reg_addr[i*6 +: 6] == icsq_pkg::CAL_RESET_MODE_REG)
                && mode_reg_data[i*8 + icsq_pkg::CAL_RESET_BIT];
        end
    end

    generate
        for (genvar g = 0; g < 2; g++) begin : g_chan
            icsq_chan #(
                .CODE_W     (CODE_W)
            ) u_chan (
                .mclk       (mclk),
                .rst_b      (rst_b),
                .apply      (apply_ok[g]),
                .dflt       (dflt_req[g]),
                .result     (s.result),
                .code       (chan_code[g]),
                .busy       (chan_busy[g]),
                .is_default (chan_dflt[g])
            );
        end
    endgenerate

    logic begin_any;
    logic begin_ok;

    always_comb begin
        next_s = s;
        // measurement code arrives from the analog comparator
        next_s.meas_s1 = cal_resistor_pin_code;
        next_s.meas_s2 = s.meas_s1;
        next_s.meas_s3 = s.meas_s2;
        // code bits may settle on different edges; trust only a value
        // seen equal on two edges in a row
        if (s.meas_s2 == s.meas_s3) begin
            next_s.meas_hold = s.meas_s3;
        end

        // either channel, or both at once, may start the shared engine
        begin_any = |(multipurpose_command_begin & ~power_down);
        begin_ok  = begin_any && s.ctrl_enable && !s.running;

        if (s.running) begin
            next_s.run_cnt = s.run_cnt + 8'h01;
            if (s.run_cnt == RUN_LAST) begin
                // only a finished run replaces the result the channels load
                next_s.running      = 1'b0;
                next_s.result       = s.meas_hold;
                next_s.result_valid = 1'b1;
            end
        end else if (begin_ok) begin
            next_s.running = 1'b1;
            next_s.run_cnt = 8'h00;
        end
        if (reg_write) begin
            if (reg_addr == icsq_pkg::REG_CTRL) begin
                next_s.ctrl_enable = reg_wdata[icsq_pkg::CTRL_ENABLE_BIT];
            end else if (reg_addr == icsq_pkg::REG_IGNORE) begin
                next_s.ignore_cnt = 16'h0000;
            end
        end

        // an ignored begin in the same cycle as a clear still counts
        if (begin_any && s.running && next_s.ignore_cnt != 16'hffff) begin
            next_s.ignore_cnt = next_s.ignore_cnt + 16'h0001;
        end

        next_s.rdata = 32'h0000_0000;
        if (reg_read) begin
            if (reg_addr == icsq_pkg::REG_CTRL) begin
                next_s.rdata = {31'h0, s.ctrl_enable};
            end else if (reg_addr == icsq_pkg::REG_STATUS) begin
                next_s.rdata = {26'h0, chan_dflt, chan_busy,
                                s.result_valid, s.running};
            end else if (reg_addr == icsq_pkg::REG_RESULT) begin
                next_s.rdata = 32'(s.result);
            end else if (reg_addr == icsq_pkg::REG_CODE0) begin
                next_s.rdata = 32'(chan_code[0]);
            end else if (reg_addr == icsq_pkg::REG_CODE1) begin
                next_s.rdata = 32'(chan_code[1]);
            end else if (reg_addr == icsq_pkg::REG_IGNORE) begin
                next_s.rdata = {16'h0, s.ignore_cnt};
            end else begin
                next_s.rdata = 32'h0000_0000;
            end
        end

        // ports come from flops; one cycle behind the channel codes
        next_s.out_code0   = chan_code[0];
        next_s.out_code1   = chan_code[1];
        next_s.out_running = next_s.running;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s.meas_s1      <= '0;
            s.meas_s2      <= '0;
            s.meas_s3      <= '0;
            s.meas_hold    <= '0;
            s.running      <= 1'b0;
            s.run_cnt      <= 8'h00;
            s.result       <= CODE_W'(icsq_pkg::DEFAULT_CODE);
            s.result_valid <= 1'b0;
            s.ctrl_enable  <= icsq_pkg::CTRL_RESET[icsq_pkg::CTRL_ENABLE_BIT];
            s.ignore_cnt   <= 16'h0000;
            s.rdata        <= 32'h0000_0000;
            s.out_code0    <= CODE_W'(icsq_pkg::DEFAULT_CODE);
            s.out_code1    <= CODE_W'(icsq_pkg::DEFAULT_CODE);
            s.out_running  <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata       = s.rdata;
    assign drive_code0     = s.out_code0;
    assign drive_code1     = s.out_code1;
    assign cal_in_progress = s.out_running;

endmodule : icsq_top
`default_nettype wire

//--- verif/icsq_properties.sv
`timescale 1ns/100ps
`default_nettype none
module icsq_properties #(
    parameter int CODE_W = 8
) (
    input wire logic              mclk,
    input wire logic              rst_b,
    input wire logic [1:0]        multipurpose_command_begin,
    input wire logic [1:0]        multipurpose_command_apply,
    input wire logic [1:0]        mode_reg_write,
    input wire logic [11:0]       mode_reg_addr,
    input wire logic [15:0]       mode_reg_data,
    input wire logic [1:0]        power_down,
    input wire logic [7:0]        reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_write,
    input wire logic              reg_read,
    input wire logic [31:0]       reg_rdata,
    input wire logic [CODE_W-1:0] drive_code0,
    input wire logic [CODE_W-1:0] drive_code1,
    input wire logic              cal_in_progress
);
    logic       en;
    logic [7:0] run_cnt;
    logic       take;
    logic       dflt0;
    // begin is only judged while the engine is seen idle
    assign take = |(multipurpose_command_begin & ~power_down) && en
                  && !cal_in_progress;
    assign dflt0 = mode_reg_write[0] && mode_reg_data[0]
                   && mode_reg_addr[5:0] == icsq_pkg::CAL_RESET_MODE_REG;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            en      <= 1'b1;
            run_cnt <= 8'h00;
        end else begin
            if (reg_write && reg_addr == icsq_pkg::REG_CTRL) begin
                en <= reg_wdata[0];
            end
            run_cnt <= cal_in_progress ? run_cnt + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence code0_hold; $stable(drive_code0)[*8]; endsequence
    sequence code1_hold; $stable(drive_code1)[*8]; endsequence
    begin_start_a: assert property (
        take |-> ##[1:2] cal_in_progress)
        else $error("accepted begin did not start the engine");
    run_length_a: assert property (
        $fell(cal_in_progress) |-> run_cnt == 8'h7d)
        else $error("calibration run length wrong");
    apply0_hold_a: assert property (
        multipurpose_command_apply[0] && !power_down[0] |=> code0_hold)
        else $error("channel 0 code moved during apply wait");
    apply1_hold_a: assert property (
        multipurpose_command_apply[1] && !power_down[1] |=> code1_hold)
        else $error("channel 1 code moved during apply wait");
    default_code_a: assert property (
        dflt0 |-> ##[8:10] drive_code0 == icsq_pkg::DEFAULT_CODE)
        else $error("default write did not restore code");
    default_other_a: assert property (
        dflt0 && !multipurpose_command_apply[1] |=> code1_hold)
        else $error("default write touched other channel");
    rdata_idle_a: assert property (!reg_read |=> reg_rdata == 32'h0)
        else $error("read data not zero outside read answer");
    unmapped_rd_a: assert property (
        reg_read && reg_addr > icsq_pkg::REG_IGNORE |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : icsq_properties
bind icsq_top icsq_properties #(.CODE_W(CODE_W)) icsq_properties_inst (.*);
`default_nettype wire

//--- verif/icsq_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module icsq_ctrl_model (
    input  wire logic        mclk,
    output logic      [1:0]  cmd_begin,
    output logic      [1:0]  cmd_apply,
    output logic      [1:0]  mr_write,
    output logic      [11:0] mr_addr,
    output logic      [15:0] mr_data
);
    initial begin
        cmd_begin = 2'h0;
        cmd_apply = 2'h0;
        mr_write  = 2'h0;
        mr_addr   = 12'h000;
        mr_data   = 16'h0000;
    end
    // one command slot, then deselect; idle lanes toggle, so after a default request
    // each later slot repeats its address and data with mr_write low
    task automatic issue(input logic [1:0] b, input logic [1:0] a,
                         input logic [1:0] d);
        int gap;
        gap = (|a) ? icsq_pkg::CAL_APPLY_CYC + 2 : 1;
        if (|d) gap = icsq_pkg::CAL_DFLT_CYC + 2;
        @(posedge mclk);
        cmd_begin <= b;
        cmd_apply <= a;
        mr_write  <= d;
        mr_addr   <= (|d) ? {2{icsq_pkg::CAL_RESET_MODE_REG}} : ~mr_addr;
        mr_data   <= (|d) ? 16'h0101 : ~mr_data;
        @(posedge mclk);
        cmd_begin <= 2'h0;
        cmd_apply <= 2'h0;
        mr_write  <= 2'h0;
        mr_addr   <= ~mr_addr;
        mr_data   <= ~mr_data;
        repeat (gap) @(posedge mclk);
    endtask : issue
endmodule : icsq_ctrl_model
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic [1:0]  power_down = 2'h0;
    logic [7:0]  pin_code = 8'h00;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic [7:0]  dc0, dc1, c1, c2;
    logic        busy;
    logic [1:0]  cb, ca, cw;
    logic [11:0] cma;
    logic [15:0] cmd;
    int          mismatches = 0;
    int          n_compared = 0;
    always #4 mclk = ~mclk;
    icsq_top icsq_top_inst (.mclk(mclk), .rst_b(rst_b),
        .multipurpose_command_begin(cb), .multipurpose_command_apply(ca),
        .mode_reg_write(cw), .mode_reg_addr(cma), .mode_reg_data(cmd),
        .power_down(power_down), .cal_resistor_pin_code(pin_code),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .drive_code0(dc0),
        .drive_code1(dc1), .cal_in_progress(busy));
    icsq_ctrl_model icsq_ctrl_model_inst (.mclk(mclk), .cmd_begin(cb),
        .cmd_apply(ca), .mr_write(cw), .mr_addr(cma), .mr_data(cmd));
    function automatic logic [31:0] exp_status(input logic v,
                                               input logic [1:0] f);
        return {26'h0, f, 2'b00, v, 1'b0};
    endfunction : exp_status
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a8, input logic [31:0] d);
        @(posedge mclk);
        reg_write <= 1'b1;
        reg_addr  <= a8;
        reg_wdata <= d;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a8, input logic [31:0] e);
        @(posedge mclk);
        reg_read <= 1'b1;
        reg_addr <= a8;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    // bounded wait for the running calibration to end
    task automatic wait_run;
        repeat (2) @(posedge mclk);
        #1 chk(32'(busy), 32'h1);
        for (int i = 0; i < 200; i++) begin
            if (busy !== 1'b1) break;
            @(posedge mclk);
            #1;
        end
        chk(32'(busy), 32'h0);
    endtask : wait_run
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    initial begin
        #(8 * 4000);
        mismatches++;
        final_report;
    end
    initial begin
        c1 = 8'($urandom(32'h87df));
        c2 = c1 ^ (8'($urandom) | 8'h01);
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        rd(icsq_pkg::REG_CTRL, icsq_pkg::CTRL_RESET);
        rd(icsq_pkg::REG_STATUS, exp_status(1'b0, 2'h3));
        rd(icsq_pkg::REG_RESULT, 32'(icsq_pkg::DEFAULT_CODE));
        rd(8'h20, 32'h0);
        chk(32'({dc1, dc0}), 32'({2{icsq_pkg::DEFAULT_CODE}}));
        pin_code <= c1;
        icsq_ctrl_model_inst.issue(2'h3, 2'h0, 2'h0);
        icsq_ctrl_model_inst.issue(2'h1, 2'h0, 2'h0);
        rd(icsq_pkg::REG_STATUS, exp_status(1'b0, 2'h3) | 32'h1);
        wait_run;
        rd(icsq_pkg::REG_IGNORE, 32'h1);
        wr(icsq_pkg::REG_IGNORE, 32'h0);
        rd(icsq_pkg::REG_IGNORE, 32'h0);
        rd(icsq_pkg::REG_RESULT, 32'(c1));
        icsq_ctrl_model_inst.issue(2'h0, 2'h3, 2'h0);
        chk(32'({dc1, dc0}), 32'({c1, c1}));
        icsq_ctrl_model_inst.issue(2'h0, 2'h0, 2'h1);
        chk(32'({dc1, dc0}), 32'({c1, icsq_pkg::DEFAULT_CODE}));
        rd(icsq_pkg::REG_STATUS, exp_status(1'b1, 2'h1));
        pin_code <= c2;
        icsq_ctrl_model_inst.issue(2'h2, 2'h0, 2'h0);
        icsq_ctrl_model_inst.issue(2'h0, 2'h1, 2'h0);
        chk(32'(dc0), 32'(c1));
        wait_run;
        icsq_ctrl_model_inst.issue(2'h0, 2'h2, 2'h0);
        chk(32'({dc1, dc0}), 32'({c2, c1}));
        wr(icsq_pkg::REG_CTRL, 32'h0);
        icsq_ctrl_model_inst.issue(2'h3, 2'h0, 2'h0);
        repeat (3) @(posedge mclk);
        #1 chk(32'(busy), 32'h0);
        wr(icsq_pkg::REG_CTRL, 32'h1);
        power_down <= 2'h3;
        icsq_ctrl_model_inst.issue(2'h3, 2'h1, 2'h0);
        repeat (3) @(posedge mclk);
        #1 chk(32'(busy), 32'h0);
        chk(32'(dc0), 32'(c1));
        power_down <= 2'h0;
        final_report;
    end
endmodule : testbench
`default_nettype wire
